// file: src/fpec_regs.svh
/*
 flash program/erase control: register offsets, field positions,
 codes and timing figures as macros.
 assumes inclusion by bare name from the package and the design.
*/
`ifndef FPEC_REGS_SVH
`define FPEC_REGS_SVH
`define FPEC_CTRL_OFF 8'h00
`define FPEC_ADRL_OFF 8'h04
`define FPEC_ADRH_OFF 8'h08
`define FPEC_KEY_OFF 8'h0C
`define FPEC_STAT_OFF 8'h10
`define FPEC_MASK_OFF 8'h14
`define FPEC_START_BIT 15
`define FPEC_EN_BIT 14
`define FPEC_ERR_BIT 13
`define FPEC_SB_BIT 12
`define FPEC_RDF_BIT 9
`define FPEC_UR_BIT 8
`define FPEC_STAT_DONE 0
`define FPEC_STAT_ERR 1
`define FPEC_OP_BULK 4'hE
`define FPEC_OP_PAGE 4'h3
`define FPEC_OP_ROW 4'h2
`define FPEC_OP_DWORD 4'h1
`define FPEC_KEY1 8'h55
`define FPEC_KEY2 8'hAA
`define FPEC_RESP_OKAY 2'h0
`define FPEC_RESP_SLVERR 2'h2
`define FPEC_CLK_NS 100
`define FPEC_WAKE_NS 10000
`endif

// file: src/fpec_pkg.sv
/*
 flash program/erase control: shared types.
 assumes fpec_regs.svh is on the include path.
*/
package fpec_pkg;
  `include "fpec_regs.svh"

  typedef enum logic [1:0] {
    FPEC_ST_IDLE = 2'b00,
    FPEC_ST_WAKE = 2'b01,
    FPEC_ST_BUSY = 2'b10
  } fpec_state_t;

  typedef struct packed {
    logic [3:0] op;
    logic [23:0] addr;
  } fpec_flash_req_t;
endpackage

// file: src/fpec_ctrl.sv
/*
 flash program/erase control with an axi4-lite register slave.
 assumes a flash engine on the same clock that answers a start pulse
 with done or abort, and core idle/power-save signals on this clock.
*/
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "fpec_regs.svh"

// Operation
// - an improper sequence or a terminated operation sets the sequence error flag; here a start write without a valid unlock only loads it from data bit 13.
// - with idle standby set, flash stays unavailable for the wake delay after idle.
// - operation codes other than the four defined ones start nothing.
// - a power-save instruction is ignored while an operation runs.
// - double-word program targets two words on a four-word aligned boundary.
// - the start bit is honoured only right after a valid unlock sequence.
// - codes 1110, 0011, 0010, 0001 are bulk erase, page erase, row, double-word.
// - enable and sequence error clear only on power-on reset.
// - the low address register gives target bits 15 to 0.
// - the high address register gives bits 23 to 16, upper byte reads zero.
module fpec_ctrl #(
  parameter int WAKE_NS = `FPEC_WAKE_NS,
  parameter int CLK_NS = `FPEC_CLK_NS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic idle_mode,
  input wire logic power_save_instruction,
  output logic power_save_enter,
  output logic flash_available,
  output fpec_pkg::fpec_flash_req_t flash_req,
  output logic flash_start,
  input wire logic flash_done,
  input wire logic flash_abort,
  input wire logic flash_underrun,
  output logic irq
);
  import fpec_pkg::*;

  localparam int WAKE_CYC_I = (WAKE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [15:0] WAKE_CYC = 16'(WAKE_CYC_I < 1 ? 1 : WAKE_CYC_I);

  if (WAKE_CYC_I > 65535 || CLK_NS < 1) begin : g_bad_wake
    $error("wake delay does not fit the counter");
  end

  function automatic logic op_valid(input logic [3:0] op);
    return op == `FPEC_OP_BULK || op == `FPEC_OP_PAGE ||
           op == `FPEC_OP_ROW || op == `FPEC_OP_DWORD;
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] st);
    return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // state
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [7:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  fpec_state_t st_q, st_d;
  logic start_q, start_d, en_q, en_d, err_q, err_d, sb_q, sb_d;
  logic rdf_q, rdf_d, ur_q, ur_d;
  logic [3:0] op_q, op_d;
  logic [15:0] adrl_q, adrl_d;
  logic [7:0] adrh_q, adrh_d;
  logic [1:0] key_q, key_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic idle_q;
  logic [15:0] wake_q, wake_d;
  fpec_flash_req_t req_q, req_d;
  logic fstart_q, fstart_d;

  logic wr_do, rd_do, ctrl_wr, start_wr;
  logic [15:0] ctrl_rd, ctrl_new;

  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign flash_req = req_q;
  assign flash_start = fstart_q;
  assign irq = |(stat_q & mask_q);
  // idle_q covers the exit cycle, before the wake counter is loaded
  assign flash_available = !(sb_q && (idle_mode || idle_q)) && wake_q == 16'h0000;
  assign power_save_enter = power_save_instruction && st_q == FPEC_ST_IDLE;

  assign wr_do = aw_have_q && w_have_q && !bvalid_q;
  assign rd_do = s_axi_arvalid && !rvalid_q;
  assign ctrl_wr = wr_do && awaddr_q == `FPEC_CTRL_OFF;
  assign start_wr = ctrl_wr && wstrb_q[1] && wdata_q[`FPEC_START_BIT];
  assign ctrl_new = merge16(ctrl_rd, wdata_q, wstrb_q);

  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[`FPEC_START_BIT] = start_q;
    ctrl_rd[`FPEC_EN_BIT] = en_q;
    ctrl_rd[`FPEC_ERR_BIT] = err_q;
    ctrl_rd[`FPEC_SB_BIT] = sb_q;
    ctrl_rd[`FPEC_RDF_BIT] = rdf_q;
    ctrl_rd[`FPEC_UR_BIT] = ur_q;
    ctrl_rd[3:0] = op_q;
  end

  ////////////////////////////////////////////////////////////////////
  // bus slave, registers and sequencer
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    st_d = st_q;
    start_d = start_q;
    en_d = en_q;
    err_d = err_q;
    sb_d = sb_q;
    rdf_d = rdf_q;
    ur_d = ur_q;
    op_d = op_q;
    adrl_d = adrl_q;
    adrh_d = adrh_q;
    key_d = key_q;
    mask_d = mask_q;
    stat_d = stat_q;
    req_d = req_q;
    fstart_d = 1'b0;
    wake_d = (wake_q != 16'h0000) ? wake_q - 16'h0001 : wake_q;
    if (idle_q && !idle_mode && sb_q) begin
      wake_d = WAKE_CYC;
    end
    if (s_axi_awvalid && !aw_have_q) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_q) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    // read-clear of status happens first so that a same-cycle event wins
    if (rd_do) begin
      rvalid_d = 1'b1;
      rresp_d = `FPEC_RESP_OKAY;
      if (s_axi_araddr == `FPEC_CTRL_OFF) begin
        rdata_d = {16'h0000, ctrl_rd};
      end else if (s_axi_araddr == `FPEC_ADRL_OFF) begin
        rdata_d = {16'h0000, adrl_q};
      end else if (s_axi_araddr == `FPEC_ADRH_OFF) begin
        rdata_d = {24'h00_0000, adrh_q};
      end else if (s_axi_araddr == `FPEC_KEY_OFF) begin
        rdata_d = 32'h0000_0000;
      end else if (s_axi_araddr == `FPEC_STAT_OFF) begin
        rdata_d = {30'h0000_0000, stat_q};
        stat_d = 2'h0;
      end else if (s_axi_araddr == `FPEC_MASK_OFF) begin
        rdata_d = {30'h0000_0000, mask_q};
      end else begin
        rdata_d = 32'h0000_0000;
        rresp_d = `FPEC_RESP_SLVERR;
      end
    end
    if (wr_do) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = `FPEC_RESP_OKAY;
      key_d = 2'd0; // any write other than the next key step drops the unlock
      if (awaddr_q == `FPEC_CTRL_OFF) begin
        en_d = ctrl_new[`FPEC_EN_BIT];
        err_d = ctrl_new[`FPEC_ERR_BIT];
        sb_d = ctrl_new[`FPEC_SB_BIT];
        rdf_d = ctrl_new[`FPEC_RDF_BIT];
        ur_d = ctrl_new[`FPEC_UR_BIT];
        op_d = ctrl_new[3:0];
      end else if (awaddr_q == `FPEC_ADRL_OFF) begin
        adrl_d = merge16(adrl_q, wdata_q, wstrb_q);
      end else if (awaddr_q == `FPEC_ADRH_OFF) begin
        adrh_d = wstrb_q[0] ? wdata_q[7:0] : adrh_q;
      end else if (awaddr_q == `FPEC_KEY_OFF) begin
        if (wstrb_q[0] && wdata_q[7:0] == `FPEC_KEY1) begin
          key_d = 2'd1;
        end else if (wstrb_q[0] && key_q == 2'd1 && wdata_q[7:0] == `FPEC_KEY2) begin
          key_d = 2'd2;
        end
      end else if (awaddr_q == `FPEC_STAT_OFF) begin
        stat_d = stat_d;
      end else if (awaddr_q == `FPEC_MASK_OFF) begin
        mask_d = wstrb_q[0] ? wdata_q[1:0] : mask_q;
      end else begin
        bresp_d = `FPEC_RESP_SLVERR;
      end
    end
    case (st_q)
      FPEC_ST_IDLE: begin
        if (start_wr && key_q == 2'd2) begin
          if (!ctrl_new[`FPEC_EN_BIT] || !op_valid(ctrl_new[3:0])) begin
            err_d = 1'b1;
            stat_d[`FPEC_STAT_ERR] = 1'b1;
          end else begin
            st_d = FPEC_ST_WAKE;
            start_d = 1'b1;
            req_d.op = ctrl_new[3:0];
            req_d.addr = {adrh_q, adrl_q};
            if (ctrl_new[3:0] == `FPEC_OP_DWORD) begin
              req_d.addr[1:0] = 2'b00;
            end
          end
        end
      end
      FPEC_ST_WAKE: begin
        if (flash_available) begin
          st_d = FPEC_ST_BUSY;
          fstart_d = 1'b1;
        end
      end
      FPEC_ST_BUSY: begin
        if (flash_underrun) begin
          ur_d = 1'b1;
        end
        if (flash_abort) begin
          err_d = 1'b1;
          stat_d[`FPEC_STAT_ERR] = 1'b1;
          start_d = 1'b0;
          st_d = FPEC_ST_IDLE;
        end else if (flash_done) begin
          stat_d[`FPEC_STAT_DONE] = 1'b1;
          start_d = 1'b0;
          st_d = FPEC_ST_IDLE;
        end
      end
      default: st_d = FPEC_ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!por_n) begin
      en_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      en_q <= en_d;
      err_q <= err_d;
    end
    if (!por_n || !aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'h0;
      rvalid_q <= 1'b0;
      rresp_q <= 2'h0;
      rdata_q <= 32'h0000_0000;
      st_q <= FPEC_ST_IDLE;
      start_q <= 1'b0;
      sb_q <= 1'b0;
      rdf_q <= 1'b0;
      ur_q <= 1'b0;
      op_q <= 4'h0;
      adrl_q <= 16'h0000;
      adrh_q <= 8'h00;
      key_q <= 2'd0;
      stat_q <= 2'h0;
      mask_q <= 2'h0;
      idle_q <= 1'b0;
      wake_q <= 16'h0000;
      req_q <= '0;
      fstart_q <= 1'b0;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
      st_q <= st_d;
      start_q <= start_d;
      sb_q <= sb_d;
      rdf_q <= rdf_d;
      ur_q <= ur_d;
      op_q <= op_d;
      adrl_q <= adrl_d;
      adrh_q <= adrh_d;
      key_q <= key_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      idle_q <= idle_mode;
      wake_q <= wake_d;
      req_q <= req_d;
      fstart_q <= fstart_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // checks
  sequence s_busy_abort;
    st_q == FPEC_ST_BUSY && flash_abort;
  endsequence

  property p_abort_err;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    s_busy_abort |=> err_q && st_q == FPEC_ST_IDLE && !start_q;
  endproperty
  a_abort_err: assert property (p_abort_err) else $error("abort left no error");

  property p_wake;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    (idle_q && !idle_mode && sb_q) |-> !flash_available [*4];
  endproperty
  a_wake: assert property (p_wake) else $error("flash available too early");

  property p_bad_op;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    (st_q == FPEC_ST_IDLE && start_wr && key_q == 2'd2 && !op_valid(ctrl_new[3:0]))
      |=> st_q == FPEC_ST_IDLE && err_q ##1 !flash_start;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("reserved code started");

  property p_psave;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    st_q != FPEC_ST_IDLE |-> !power_save_enter;
  endproperty
  a_psave: assert property (p_psave) else $error("power save during operation");

  property p_dword;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    flash_start && flash_req.op == `FPEC_OP_DWORD |-> flash_req.addr[1:0] == 2'b00;
  endproperty
  a_dword: assert property (p_dword) else $error("double word unaligned");

  property p_locked;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    (st_q == FPEC_ST_IDLE && start_wr && key_q != 2'd2) |=> st_q == FPEC_ST_IDLE [*2];
  endproperty
  a_locked: assert property (p_locked) else $error("start without unlock");

  property p_enable;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    st_q == FPEC_ST_IDLE && st_d == FPEC_ST_WAKE |-> ctrl_new[`FPEC_EN_BIT] ##1 start_q;
  endproperty
  a_enable: assert property (p_enable) else $error("start while disabled");

  property p_codes;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    flash_start |-> op_valid(flash_req.op) && $past(st_q) == FPEC_ST_WAKE;
  endproperty
  a_codes: assert property (p_codes) else $error("undefined code issued");

  property p_por_only;
    @(posedge aclk) disable iff (!por_n)
    !aresetn |=> en_q == $past(en_d) && err_q == $past(err_d);
  endproperty
  a_por_only: assert property (p_por_only) else $error("enable lost on reset");

  property p_addr;
    @(posedge aclk) disable iff (!aresetn || !por_n)
    (st_q == FPEC_ST_IDLE && st_d == FPEC_ST_WAKE && op_d != `FPEC_OP_DWORD)
      |=> flash_req.addr == {$past(adrh_q), $past(adrl_q)};
  endproperty
  a_addr: assert property (p_addr) else $error("target address wrong");
endmodule // fpec_ctrl

`default_nettype wire

// file: verification/tb_top.sv
/*
 self-checking bench for fpec_ctrl, driven over axi4-lite.
 assumes fpec_pkg and fpec_regs.svh are compiled before this file.
*/
`timescale 1ns/10ps
`default_nettype none
`include "fpec_regs.svh"
module tb_top;
  import fpec_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por_n = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [3:0] wstrb = 4'h3;
  logic idle_mode = 1'b0;
  logic psi = 1'b1;
  logic fdone = 1'b0;
  logic fabort = 1'b0;
  logic funder = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pse, favail, fstart, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, r;
  fpec_flash_req_t freq;
  logic [33:0] q_rd[$];
  logic [33:0] q_req[$];
  int fail_count = 0;
  int n_tests = 0;
  int n_st = 0;
  int seed = 32'hb493;
  logic [23:0] adr = 24'h00_0000;
  logic [1:0] msk = 2'b11;

  always #50 aclk = ~aclk;

  fpec_ctrl #(.WAKE_NS(300), .CLK_NS(100)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .por_n(por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .idle_mode(idle_mode), .power_save_instruction(psi), .power_save_enter(pse),
    .flash_available(favail), .flash_req(freq), .flash_start(fstart),
    .flash_done(fdone), .flash_abort(fabort), .flash_underrun(funder), .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    $display("compared %0d, mismatched %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string s, input logic [33:0] e, input logic [33:0] v);
    n_tests++;
    if (v !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", s, e, v);
    end
  endtask

  task automatic hang;
    fail_count++;
    close_out();
  endtask

  // handshakes sampled at the falling edge, so no race with the slave's flops
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic hb, ta, tw;
    n = 0;
    hb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb && n < 40) begin
      @(negedge aclk);
      hb = bvalid;
      ta = awvalid && awready;
      tw = wvalid && wready;
      if (hb) chk("bresp", 34'(er), 34'(bresp));
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    if (!hb) hang();
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    logic hr, ta;
    n = 0;
    hr = 1'b0;
    q_rd.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hr && n < 40) begin
      @(negedge aclk);
      hr = rvalid;
      ta = arvalid && arready;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    if (!hr) hang();
  endtask

  // the oldest note is taken whenever a read or a start shows up
  always @(negedge aclk) begin
    if (rvalid === 1'b1 && rready) begin
      if (q_rd.size() == 0) chk("read_extra", 34'h0, 34'h1);
      else chk("read", q_rd.pop_front(), {rresp, rdata});
    end
    if (fstart !== 1'b0) begin
      n_st++;
      if (q_req.size() == 0) chk("flash_start", 34'h0, 34'h1);
      else chk("flash_req", q_req.pop_front(), 34'(freq));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic op(input logic [3:0] c, input logic en, input logic ab);
    logic ok;
    logic [1:0] st;
    int n, k;
    ok = en && (c == 4'hE || c == 4'h3 || c == 4'h2 || c == 4'h1);
    st = (ok && !ab) ? 2'b01 : 2'b10;
    n = 0;
    k = n_st;
    wr(`FPEC_KEY_OFF, 32'(`FPEC_KEY1), 2'b00);
    wr(`FPEC_KEY_OFF, 32'(`FPEC_KEY2), 2'b00);
    if (ok) q_req.push_back({6'h0, c, adr[23:2], (c == 4'h1) ? 2'b00 : adr[1:0]});
    wr(`FPEC_CTRL_OFF, 32'h0000_8000 | (32'(en) << 14) | 32'(c), 2'b00);
    if (ok) begin
      while (n_st == k && n < 50) begin
        @(negedge aclk);
        n++;
      end
      @(posedge aclk);
      funder <= (c == 4'h2);
      @(posedge aclk);
      funder <= 1'b0;
      fdone <= !ab;
      fabort <= ab;
      @(negedge aclk);
      chk("power_save_enter", 34'h0, 34'(pse));
      @(posedge aclk);
      fdone <= 1'b0;
      fabort <= 1'b0;
    end
    if (n >= 50) hang();
    rd(`FPEC_CTRL_OFF, {19'h0, en, !ok || ab, 4'h0, ok && c == 4'h2, 4'h0, c});
    @(negedge aclk);
    chk("irq", 34'(|(st & msk)), 34'(irq));
    @(posedge aclk);
    rd(`FPEC_STAT_OFF, {32'h0000_0000, st});
    @(negedge aclk);
    chk("irq_clear", 34'h0, 34'(irq));
    chk("power_save_idle", 34'h1, 34'(pse));
    @(posedge aclk);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    por_n <= 1'b1;
    r = $random(seed);
    adr = 24'($random(seed)) | 24'h00_0003;
    wr(`FPEC_MASK_OFF, 32'h0000_0003, 2'b00);
    wr(`FPEC_ADRL_OFF, {r[31:16], adr[15:0]}, 2'b00);
    wr(`FPEC_ADRH_OFF, {r[23:0], adr[23:16]}, 2'b00);
    rd(`FPEC_ADRL_OFF, {18'h0, adr[15:0]});
    rd(`FPEC_ADRH_OFF, {26'h0, adr[23:16]});
    wstrb <= 4'h1;
    wr(`FPEC_ADRL_OFF, {16'hffff, ~adr[15:0]}, 2'b00);
    wstrb <= 4'h3;
    rd(`FPEC_ADRL_OFF, {18'h0, adr[15:8], ~adr[7:0]});
    wr(`FPEC_ADRL_OFF, {r[31:16], adr[15:0]}, 2'b00);
    rd(`FPEC_ADRL_OFF, {18'h0, adr[15:0]});
    rd(`FPEC_KEY_OFF, 34'h0);
    rd(8'h18, {2'b10, 32'h0000_0000});
    $display("test registers finished");
    for (int i = 0; i < 16; i++) op(4'(i), 1'b1, 1'b0);
    $display("test operation codes finished");
    msk = 2'b01;
    wr(`FPEC_MASK_OFF, 32'h0000_0001, 2'b00);
    op(4'h2, 1'b0, 1'b0);
    msk = 2'b11;
    wr(`FPEC_MASK_OFF, 32'h0000_0003, 2'b00);
    $display("test disabled start finished");
    wr(`FPEC_KEY_OFF, 32'(`FPEC_KEY1), 2'b00);
    wr(`FPEC_KEY_OFF, 32'(`FPEC_KEY2), 2'b00);
    wr(`FPEC_ADRL_OFF, {16'h0000, adr[15:0]}, 2'b00);
    wr(`FPEC_CTRL_OFF, 32'h0000_C002, 2'b00);
    rd(`FPEC_CTRL_OFF, 34'h0_4002);
    rd(`FPEC_STAT_OFF, 34'h0);
    $display("test broken unlock finished");
    op(4'h3, 1'b1, 1'b1);
    $display("test abort finished");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`FPEC_CTRL_OFF, 34'h0_6000);
    por_n <= 1'b0;
    repeat (2) @(posedge aclk);
    por_n <= 1'b1;
    rd(`FPEC_CTRL_OFF, 34'h0);
    $display("test reset sources finished");
    wr(`FPEC_CTRL_OFF, 32'h0000_1000, 2'b00);
    idle_mode <= 1'b1;
    repeat (2) @(negedge aclk);
    chk("flash_available_idle", 34'h0, 34'(favail));
    @(posedge aclk);
    idle_mode <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(negedge aclk);
      chk("flash_available_wake", 34'h0, 34'(favail));
    end
    repeat (4) @(negedge aclk);
    chk("flash_available_after", 34'h1, 34'(favail));
    $display("test idle standby finished");
    @(posedge aclk);
    psi <= 1'b0;
    @(negedge aclk);
    chk("power_save_off", 34'h0, 34'(pse));
    $display("test power save request finished");
    close_out();
  end
endmodule // tb_top
`default_nettype wire
